// ---- rtl/mfp_top.sv ----
// mfp_top: fault deglitch, latch, bridge disable, fault flag and chop timebase
// assumes detector and pin inputs are asynchronous; the analog comparators sit outside
`timescale 1ns/10ps

// Behaviour
// - open or grounded pin uses internal oscillator
// - over-temperature after 5us forces bridge off
// - over-current after 1.25us forces all off
// - low-side and high-side over-current both trip
// - thermal/current fault latched until repower/sleep
// - supply low 1.41us forces off, resets logic
// - lockout leaves itself when supply recovers
// - fault flag pulled low while fault latched
// - fast decay six cycles, slow fills rest
module mfp_top (
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire mfp_pkg::mfp_det_s det_raw,
  input  wire logic              sleep_b,
  input  wire logic              osc_ext_present,
  input  wire logic              chop_osc_pin,
  input  wire logic              charge_done,
  output logic                   bridge_off,
  output logic                   fault_flag_out_o,
  output logic                   fault_flag_out_oe,
  output logic                   chop_start,
  output mfp_pkg::mfp_phase_e    decay_phase,
  output logic                   logic_reset
);
  // terminal counts of the deglitch, divider and chop counters
  localparam int unsigned   CW        = mfp_pkg::CNT_W;
  localparam logic [CW-1:0] OT_LAST   = CW'(mfp_pkg::OTEMP_CYC - 1);
  localparam logic [CW-1:0] OC_LAST   = CW'(mfp_pkg::OCUR_CYC - 1);
  localparam logic [CW-1:0] UV_LAST   = CW'(mfp_pkg::ULOW_CYC - 1);
  localparam logic [CW-1:0] DIV_LAST  = CW'(mfp_pkg::OSC_DEF_DIV - 1);
  localparam logic [3:0]    CHOP_LAST = 4'(mfp_pkg::CHOP_DIV - 1);
  mfp_pkg::mfp_state_s s_q;
  mfp_pkg::mfp_state_s s_d;
  logic                ot_s;
  logic                ocl_s;
  logic                och_s;
  logic                uv_s;
  logic                slp_s;
  logic                ext_s;
  logic                osc_tick;
  logic                pin_s;

  // a level changes once the second and third stages agree, else it holds
  assign ot_s  = (s_q.sync_a[1] == s_q.sync_a[2]) ? s_q.sync_a[2] : s_q.agreed[0];
  assign ocl_s = (s_q.sync_b[1] == s_q.sync_b[2]) ? s_q.sync_b[2] : s_q.agreed[1];
  assign och_s = (s_q.sync_c[1] == s_q.sync_c[2]) ? s_q.sync_c[2] : s_q.agreed[2];
  assign uv_s  = (s_q.sync_d[1] == s_q.sync_d[2]) ? s_q.sync_d[2] : s_q.agreed[3];
  assign slp_s = ~((s_q.sync_e[1] == s_q.sync_e[2]) ? s_q.sync_e[2] : s_q.agreed[4]);
  assign ext_s = (s_q.sync_f[1] == s_q.sync_f[2]) ? s_q.sync_f[2] : s_q.agreed[5];
  assign pin_s = (s_q.sync_g[1] == s_q.sync_g[2]) ? s_q.sync_g[2] : s_q.osc_prev;

  always_comb
  begin
    s_d = s_q;
    osc_tick = 1'b0;
    s_d.sync_a = {s_q.sync_a[1:0], det_raw.over_temp_detect};
    s_d.sync_b = {s_q.sync_b[1:0], det_raw.over_cur_low};
    s_d.sync_c = {s_q.sync_c[1:0], det_raw.over_cur_high};
    s_d.sync_d = {s_q.sync_d[1:0], det_raw.supply_low};
    s_d.sync_e = {s_q.sync_e[1:0], sleep_b};
    s_d.sync_f = {s_q.sync_f[1:0], osc_ext_present};
    s_d.sync_g = {s_q.sync_g[1:0], chop_osc_pin};
    s_d.agreed = {ext_s, ~slp_s, uv_s, och_s, ocl_s, ot_s};
    s_d.chop_start = 1'b0;
    // deglitch counters restart when the synchronised input drops
    if (!ot_s)
    begin
      s_d.ot_cnt = mfp_pkg::CNT_ZERO;
      s_d.ot_ok  = 1'b0;
    end
    else if (s_q.ot_cnt == OT_LAST)
      s_d.ot_ok = 1'b1;
    else
      s_d.ot_cnt = s_q.ot_cnt + 8'h01;
    if (!(ocl_s | och_s))
    begin
      s_d.oc_cnt = mfp_pkg::CNT_ZERO;
      s_d.oc_ok  = 1'b0;
    end
    else if (s_q.oc_cnt == OC_LAST)
      s_d.oc_ok = 1'b1;
    else
      s_d.oc_cnt = s_q.oc_cnt + 8'h01;
    if (!uv_s)
    begin
      s_d.uv_cnt = mfp_pkg::CNT_ZERO;
      s_d.uv_ok  = 1'b0;
    end
    else if (s_q.uv_cnt == UV_LAST)
      s_d.uv_ok = 1'b1;
    else
      s_d.uv_cnt = s_q.uv_cnt + 8'h01;
    // fault latch: set wins; sleep or lockout clears it
    if (s_q.ot_ok | s_q.oc_ok)
      s_d.latched = 1'b1;
    else if (slp_s | s_q.uv_ok)
      s_d.latched = 1'b0;
    // oscillator source: external pin edges or internal divider
    s_d.osc_prev = pin_s;
    if (ext_s)
    begin
      osc_tick = pin_s & ~s_q.osc_prev;
      s_d.osc_div = mfp_pkg::CNT_ZERO;
    end
    else if (s_q.osc_div == DIV_LAST)
    begin
      osc_tick = 1'b1;
      s_d.osc_div = mfp_pkg::CNT_ZERO;
    end
    else
      s_d.osc_div = s_q.osc_div + 8'h01;
    // chop timebase and decay phases
    if (osc_tick)
    begin
      if (s_q.phase_cnt == CHOP_LAST)
      begin
        s_d.phase_cnt  = mfp_pkg::PH_ZERO;
        s_d.chop_start = 1'b1;
        s_d.phase      = mfp_pkg::MFP_CHARGE;
      end
      else
      begin
        s_d.phase_cnt = s_q.phase_cnt + 4'h1;
        case (s_q.phase)
          mfp_pkg::MFP_CHARGE:
            if (charge_done)
            begin
              s_d.phase     = mfp_pkg::MFP_FAST;
              s_d.fast_left = 4'(mfp_pkg::FAST_CYC - 1);
            end
          mfp_pkg::MFP_FAST:
            if (s_q.fast_left == mfp_pkg::PH_ZERO)
              s_d.phase = mfp_pkg::MFP_SLOW;
            else
              s_d.fast_left = s_q.fast_left - 4'h1;
          mfp_pkg::MFP_SLOW:
            s_d.phase = mfp_pkg::MFP_SLOW;
          default:
            s_d.phase = mfp_pkg::MFP_CHARGE;
        endcase
      end
    end
    s_d.bridge_off = s_d.latched | s_d.uv_ok | slp_s;
    // lockout resets the chop phase counter, decay phase and fast count; the divider keeps running
    if (s_q.uv_ok)
    begin
      s_d.phase_cnt = mfp_pkg::PH_ZERO;
      s_d.phase     = mfp_pkg::MFP_CHARGE;
      s_d.fast_left = mfp_pkg::PH_ZERO;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q            <= '0;
      s_q.bridge_off <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign bridge_off        = s_q.bridge_off;
  assign fault_flag_out_o  = 1'b0;
  assign fault_flag_out_oe = s_q.latched;
  assign chop_start        = s_q.chop_start;
  assign decay_phase       = s_q.phase;
  assign logic_reset       = s_q.uv_ok;

  // protection and timebase checks
  chk_fault_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s_q.ot_ok | s_q.oc_ok) |=> bridge_off) else $error("fault did not turn bridge off");
  chk_latch_set: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s_q.ot_ok | s_q.oc_ok) |=> s_q.latched) else $error("fault not latched");
  chk_flag_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s_q.ot_ok | s_q.oc_ok) |=> fault_flag_out_oe && !fault_flag_out_o) else $error("flag not low");
  chk_ot_glitch: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !ot_s |=> !s_q.ot_ok) else $error("thermal fault without persistence");
  chk_oc_glitch: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !(ocl_s | och_s) |=> !s_q.oc_ok) else $error("current fault without persistence");
  chk_uv_glitch: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !uv_s |=> s_q.uv_cnt == mfp_pkg::CNT_ZERO) else $error("lockout counter did not restart");
  chk_oc_source: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (ocl_s ^ och_s) && s_q.oc_cnt == OC_LAST |=> s_q.oc_ok) else $error("one-sided over-current ignored");
  chk_oc_delay: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(s_q.oc_ok) |-> $past(s_q.oc_cnt) == OC_LAST) else $error("oc timing");
  chk_ot_delay: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(s_q.ot_ok) |-> $past(s_q.ot_cnt) == OT_LAST) else $error("ot timing");
  chk_uv_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_q.uv_ok |-> bridge_off && logic_reset) else $error("lockout did not disable bridge");
  chk_uv_exit: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !uv_s |=> !s_q.uv_ok) else $error("lockout did not release");
  chk_chop_wrap: assert property (@(posedge ref_clk) disable iff (!rst_b)
    chop_start |-> s_q.phase_cnt == mfp_pkg::PH_ZERO) else $error("chop period wrong");
  chk_chop_phase: assert property (@(posedge ref_clk) disable iff (!rst_b)
    chop_start |-> decay_phase == mfp_pkg::MFP_CHARGE) else $error("period did not start in charge");
  chk_div_tick: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !ext_s && s_q.osc_div == DIV_LAST |-> osc_tick) else $error("internal oscillator tick missing");
  chk_fast_exit: assert property (@(posedge ref_clk) disable iff (!rst_b)
    osc_tick && s_q.phase == mfp_pkg::MFP_FAST && s_q.fast_left == mfp_pkg::PH_ZERO
    && s_q.phase_cnt != CHOP_LAST && !s_q.uv_ok |=> decay_phase == mfp_pkg::MFP_SLOW)
    else $error("fast decay did not end");
  chk_latch_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_q.latched && !slp_s && !s_q.uv_ok |=> s_q.latched) else $error("latch dropped");
  chk_sleep_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
    slp_s |=> bridge_off) else $error("sleep did not disable bridge");

  // coverage of the main scenarios
  cov_ot: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(s_q.ot_ok));
  cov_oc: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(s_q.oc_ok));
  cov_clear: cover property (@(posedge ref_clk) disable iff (!rst_b) $fell(s_q.latched));
  cov_fast: cover property (@(posedge ref_clk) disable iff (!rst_b) decay_phase == mfp_pkg::MFP_FAST);
  cov_slow: cover property (@(posedge ref_clk) disable iff (!rst_b) decay_phase == mfp_pkg::MFP_SLOW);
endmodule // mfp_top

// ---- rtl/mfp_pkg.sv ----
// mfp_pkg: constants and carrier types for the fault protection and chop timebase
// assumes a 25 MHz ref_clk; all deglitch counts are derived from it
package mfp_pkg;
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned CHOP_DIV        = 16;
  localparam int unsigned FAST_CYC        = 6;
  localparam int unsigned OSC_DEF_HZ      = 914000;
  localparam int unsigned OTEMP_NS        = 5000;
  localparam int unsigned OCUR_NS         = 1250;
  localparam int unsigned ULOW_NS         = 1410;
  localparam int unsigned CLK_PERIOD_NS   = 1000000000 / CLK_HZ;
  localparam int unsigned OTEMP_CYC       = (OTEMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OCUR_CYC        = (OCUR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ULOW_CYC        = (ULOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OSC_DEF_DIV     = CLK_HZ / OSC_DEF_HZ;
  localparam int unsigned CNT_W           = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 8'h00;
  localparam logic [3:0] PH_ZERO          = 4'h0;

  typedef enum logic [1:0] {
    MFP_CHARGE = 2'b00,
    MFP_FAST   = 2'b01,
    MFP_SLOW   = 2'b10
  } mfp_phase_e;

  typedef struct packed {
    logic over_temp_detect;
    logic over_cur_low;
    logic over_cur_high;
    logic supply_low;
  } mfp_det_s;

  typedef struct packed {
    logic [2:0]       sync_a;
    logic [2:0]       sync_b;
    logic [2:0]       sync_c;
    logic [2:0]       sync_d;
    logic [2:0]       sync_e;
    logic [2:0]       sync_f;
    logic [2:0]       sync_g;
    logic [5:0]       agreed;
    logic [CNT_W-1:0] ot_cnt;
    logic [CNT_W-1:0] oc_cnt;
    logic [CNT_W-1:0] uv_cnt;
    logic             ot_ok;
    logic             oc_ok;
    logic             uv_ok;
    logic             latched;
    logic [CNT_W-1:0] osc_div;
    logic             osc_prev;
    logic [3:0]       phase_cnt;
    logic [3:0]       fast_left;
    mfp_phase_e       phase;
    logic             chop_start;
    logic             bridge_off;
  } mfp_state_s;
endpackage

// ---- sim/mfp_partner.sv ----
// mfp_partner: oscillator resistor on the chop pin and winding current sense
// assumes ref_clk from the bench; ext_en says a resistor is fitted
`timescale 1ns/10ps
module mfp_partner #(
  parameter int HALF_NS = 400
) (
  input  wire logic ref_clk,
  input  wire logic ext_en,
  input  wire logic chop_start,
  output logic      osc_present,
  output logic      osc_pin,
  output logic      charge_done
);
  int cnt = 0;
  assign osc_present = ext_en;
  initial osc_pin = 1'b0;
  initial charge_done = 1'b0;
  // 1.25 MHz gives a 78 kHz chop; pin grounded when no resistor
  always #(HALF_NS) osc_pin = ext_en ? ~osc_pin : 1'b0;
  // current reaches its set value 64 clocks into each period
  always @(posedge ref_clk)
  begin
    cnt <= chop_start ? 0 : cnt + 1;
    charge_done <= !chop_start && cnt >= 63;
  end
endmodule // mfp_partner

// ---- sim/mfp_top_test.sv ----
// mfp_top_test: directed scenarios for fault protection and chop timebase
// assumes mfp_top and mfp_partner; inputs change on rising edges
`timescale 1ns/10ps
module mfp_top_test;
  logic                ref_clk = 1'b0;
  logic                rst_b   = 1'b0;
  mfp_pkg::mfp_det_s   det_raw = '0;
  logic                sleep_b = 1'b1;
  logic                ext_en  = 1'b0;
  logic                osc_present, osc_pin, charge_done, bridge_off;
  logic                flag_o, flag_oe, chop_start, logic_reset;
  mfp_pkg::mfp_phase_e decay_phase;
  int                  miscompares = 0;
  int                  compares = 0;
  int                  n;
  always #20 ref_clk = ~ref_clk;
  mfp_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .det_raw(det_raw), .sleep_b(sleep_b),
    .osc_ext_present(osc_present), .chop_osc_pin(osc_pin), .charge_done(charge_done),
    .bridge_off(bridge_off), .fault_flag_out_o(flag_o), .fault_flag_out_oe(flag_oe),
    .chop_start(chop_start), .decay_phase(decay_phase), .logic_reset(logic_reset));
  mfp_partner #(.HALF_NS(400)) partner (.ref_clk(ref_clk), .ext_en(ext_en), .chop_start(chop_start),
    .osc_present(osc_present), .osc_pin(osc_pin), .charge_done(charge_done));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // a bounded wait that ran out counts as a mismatch and ends the run
  task automatic time_out();
    miscompares++;
    final_report();
  endtask
  // cycles until bridge_off reaches v
  task automatic wait_off(input logic v, output int c);
    c = 0;
    while (bridge_off !== v)
    begin
      @(posedge ref_clk);
      #1;
      c++;
      if (c > 3000)
      begin
        miscompares++;
        final_report();
      end
    end
  endtask
  task automatic t_fault(input int b, input int cyc);
    int c;
    @(posedge ref_clk);
    det_raw[b] <= 1'b1;
    repeat (cyc - 2) @(posedge ref_clk);
    det_raw[b] <= 1'b0;
    repeat (10) @(posedge ref_clk);
    #1;
    check(bridge_off, 1'b0);
    @(posedge ref_clk);
    det_raw[b] <= 1'b1;
    wait_off(1'b1, c);
    check(c >= cyc && c <= cyc + 6, 1'b1);
    check({flag_oe, flag_o}, 2'h2);
    @(posedge ref_clk);
    det_raw[b] <= 1'b0;
    repeat (50) @(posedge ref_clk);
    #1;
    check({bridge_off, flag_oe}, 2'h3);
    @(posedge ref_clk);
    sleep_b <= 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    check(flag_oe, 1'b0);
    @(posedge ref_clk);
    sleep_b <= 1'b1;
    wait_off(1'b0, c);
    check(c <= 8, 1'b1);
    $display("fault test on bit %0d done", b);
  endtask
  task automatic t_lockout();
    int c;
    @(posedge ref_clk);
    det_raw.supply_low <= 1'b1;
    wait_off(1'b1, c);
    check(c >= mfp_pkg::ULOW_CYC && c <= mfp_pkg::ULOW_CYC + 6, 1'b1);
    check({logic_reset, flag_oe}, 2'h2);
    @(posedge ref_clk);
    det_raw.supply_low <= 1'b0;
    wait_off(1'b0, c);
    check(c <= 8, 1'b1);
    check(logic_reset, 1'b0);
    $display("lockout test done");
  endtask
  task automatic t_chop(input logic ext, input int per, input int fast);
    int c;
    int f;
    @(posedge ref_clk);
    ext_en <= ext;
    repeat (3 * per) @(posedge ref_clk);
    c = 0;
    while (chop_start !== 1'b1 && c < 2000)
    begin
      @(posedge ref_clk);
      #1;
      c++;
    end
    if (c >= 2000)
      time_out();
    c = 0;
    f = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      c++;
      f += (decay_phase === mfp_pkg::MFP_FAST);
    end
    while (chop_start !== 1'b1 && c < 2000);
    if (c >= 2000)
      time_out();
    check(c >= per - 1 && c <= per + 1, 1'b1);
    check(f >= fast - 2 && f <= fast + 2, 1'b1);
    $display("chop test ext=%0d period=%0d fast=%0d", ext, c, f);
  endtask
  initial
  begin
    repeat (7) @(posedge ref_clk);
    #1;
    check({bridge_off, flag_oe}, 2'h2);
    @(posedge ref_clk);
    rst_b <= 1'b1;
    wait_off(1'b0, n);
    check(n <= 8, 1'b1);
    t_chop(1'b0, 16 * mfp_pkg::OSC_DEF_DIV, 6 * mfp_pkg::OSC_DEF_DIV);
    t_chop(1'b1, 320, 120);
    t_fault(3, mfp_pkg::OTEMP_CYC);
    t_fault(2, mfp_pkg::OCUR_CYC);
    t_fault(1, mfp_pkg::OCUR_CYC);
    t_lockout();
    final_report();
  end
endmodule // mfp_top_test
